// file: rtl/qsf_pkg.sv
// Constants and types shared by the queue status flag logic.
// Assumes one clock (mclk, 40 ns) drives both the write and the read side.
package qsf_pkg;

    // ----------------------------------------
    // Clock and crossing windows
    // ----------------------------------------
    localparam int MCLK_PERIOD_NS = 40;
    // Write-to-read crossing window, normal mode
    localparam int TSKEW_WR_NS    = 5;
    // Write-to-read crossing window, packet mode
    localparam int TSKEW_PKT_NS   = 7;
    // Read-to-write crossing window, full and almost-full
    localparam int TSKEW_RD_NS    = 5;

    // Least times round up, never below one cycle
    localparam int SKEW_WR_CYC  = ((TSKEW_WR_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS) < 1 ? 1 :
                                  ((TSKEW_WR_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
    localparam int SKEW_PKT_CYC = ((TSKEW_PKT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS) < 1 ? 1 :
                                  ((TSKEW_PKT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
    localparam int SKEW_RD_CYC  = ((TSKEW_RD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS) < 1 ? 1 :
                                  ((TSKEW_RD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
    // Stages in a delay line; each window plus one violation cycle must fit in them
    localparam int SKEW_MAX_CYC = 4;

    // ----------------------------------------
    // Geometry and defaults
    // ----------------------------------------
    localparam int DEPTH_DEF       = 4096;
    localparam int NQ_DEF          = 4;
    // Occupancy kept in quarter words: a 9-bit word is one unit
    localparam int UNITS_PER_WORD  = 4;
    localparam int OFFSET_LO       = 8;
    localparam int OFFSET_HI       = 128;

    // ----------------------------------------
    // Bus matching ratios
    // ----------------------------------------
    typedef enum logic [2:0] {
        BUS_36_36,
        BUS_36_18,
        BUS_36_9,
        BUS_18_36,
        BUS_9_36
    } qsf_bus_t;

    localparam logic [2:0] UNITS_X9  = 3'h1;
    localparam logic [2:0] UNITS_X18 = 3'h2;
    localparam logic [2:0] UNITS_X36 = 3'h4;

endpackage

// file: rtl/qsf_delay.sv
// Crossing-window delay line for one-cycle queue events.
// Assumes len stays between 1 and MAXD while events are in flight.
`timescale 1ns/100ps
module qsf_delay #(
    parameter int MAXD = 4,
    parameter int QW   = 2
) (
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          rst,
    // Event in
    input  wire logic          in_v,
    input  wire logic [QW-1:0] in_q,
    input  wire logic [2:0]    len,
    // Event out, len cycles later
    output logic               out_v,
    output logic [QW-1:0]      out_q
);

    logic [MAXD-1:0] v_q;
    logic [QW-1:0]   q_q [MAXD];

    generate
        // The shift below needs at least two stages; len is three bits wide
        if (MAXD < 2 || MAXD > 7) begin : g_bad
            $error("qsf_delay: MAXD out of range");
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (rst) begin
            v_q <= '0;
        end else begin
            v_q <= {v_q[MAXD-2:0], in_v};
        end
    end

    always_ff @(posedge mclk) begin
        q_q[0] <= in_q;
        for (int i = 1; i < MAXD; i++) begin
            q_q[i] <= q_q[i-1];
        end
    end

    // Tap chosen at run time so a violated window costs exactly one more cycle
    always_comb begin
        out_v = 1'b0;
        out_q = '0;
        for (int i = 0; i < MAXD; i++) begin
            if (3'(i + 1) == len) begin
                out_v = v_q[i];
                out_q = q_q[i];
            end
        end
    end

endmodule

// file: rtl/qsf_flags.sv
// Status flags of a multi-queue FIFO: output-valid, full, almost-full and
// the per-queue almost-full bus.
// Assumes write and read ports both run on mclk and their inputs are synchronous.
//
// Behaviour
// - 36/36 mode: valid after first word
// - Valid after window, plus one
// - Packet timing only with 36/36 buses
// - Packet mode: valid after packet window, plus one
// - Valid drops at the read that empties
// - 36/36 both selected: full after D+1 writes
// - 36/36 write-only selected: full after D
// - 36 in, narrow out: full after D
// - 18 in: full after 2(D+1) or 2D
// - 9 in: full after 4(D+1) or 4D
// - Full at write; clears after window, plus one
// - 36/36 both selected: almost-full after D+1-m
// - Narrow out or write-only: almost-full after D-m
// - 18 or 9 in: twice or four times D+1-m, whatever the read port selects
// - Offset 8 or 128 from select at reset
// - Almost-full asserts two cycles after write
// - Almost-full clears one cycle after window
// - Bus bits: same assert and clear timing
// - Queue switch may add one cycle
// - Active flag follows write queue, second edge
`timescale 1ns/100ps
module qsf_flags #(
    parameter int DEPTH = qsf_pkg::DEPTH_DEF,
    parameter int NQ    = qsf_pkg::NQ_DEF
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    // Configuration
    input  wire logic [2:0]       bus_mode,
    input  wire logic             packet_mode,
    input  wire logic             default_offset_select,
    input  wire logic             skew_violate,
    // Write port
    input  wire logic             wr_sel_en,
    input  wire logic [$clog2(NQ)-1:0] wr_sel_addr,
    input  wire logic             wr_en,
    // Read port
    input  wire logic             rd_sel_en,
    input  wire logic [$clog2(NQ)-1:0] rd_sel_addr,
    input  wire logic             rd_en,
    // Flags
    output logic                  output_valid_n,
    output logic                  queue_full_n,
    output logic                  almost_full_n,
    output logic [NQ-1:0]         almost_full_bus
);

    // ----------------------------------------
    // Sizes and checks
    // ----------------------------------------
    localparam int QW = $clog2(NQ);
    localparam int CW = $clog2((DEPTH + 1) * qsf_pkg::UNITS_PER_WORD + 1) + 1;

    generate
        if (NQ < 2 || DEPTH < qsf_pkg::OFFSET_HI) begin : g_bad
            $error("qsf_flags: NQ or DEPTH out of range");
        end
        // A violated window adds one stage, so every window plus one must fit the line
        if (qsf_pkg::SKEW_WR_CYC + 1 > qsf_pkg::SKEW_MAX_CYC ||
            qsf_pkg::SKEW_PKT_CYC + 1 > qsf_pkg::SKEW_MAX_CYC ||
            qsf_pkg::SKEW_RD_CYC + 1 > qsf_pkg::SKEW_MAX_CYC) begin : g_bad_skew
            $error("qsf_flags: crossing window longer than the delay line");
        end
    endgenerate

    // ----------------------------------------
    // Bus matching decode
    // ----------------------------------------
    function automatic logic [2:0] in_units(input logic [2:0] m);
        case (qsf_pkg::qsf_bus_t'(m))
            qsf_pkg::BUS_18_36: in_units = qsf_pkg::UNITS_X18;
            qsf_pkg::BUS_9_36:  in_units = qsf_pkg::UNITS_X9;
            default:            in_units = qsf_pkg::UNITS_X36;
        endcase
    endfunction

    function automatic logic [2:0] out_units(input logic [2:0] m);
        case (qsf_pkg::qsf_bus_t'(m))
            qsf_pkg::BUS_36_18: out_units = qsf_pkg::UNITS_X18;
            qsf_pkg::BUS_36_9:  out_units = qsf_pkg::UNITS_X9;
            default:            out_units = qsf_pkg::UNITS_X36;
        endcase
    endfunction

    // Words to quarter-word units; thresholds and counts share one scale
    function automatic logic [CW-1:0] to_units(input logic [CW-1:0] words);
        to_units = CW'(words * CW'(qsf_pkg::UNITS_PER_WORD));
    endfunction

    logic [CW-1:0] inu;
    logic [CW-1:0] outu;
    logic          narrow_out;
    logic          narrow_in;
    logic          pkt_eff;

    assign inu        = CW'(in_units(bus_mode));
    assign outu       = CW'(out_units(bus_mode));
    assign narrow_out = (outu != CW'(qsf_pkg::UNITS_X36));
    assign narrow_in  = (inu != CW'(qsf_pkg::UNITS_X36));
    // Packet timing only holds with 36-bit buses on both ports
    assign pkt_eff    = packet_mode && (qsf_pkg::qsf_bus_t'(bus_mode) == qsf_pkg::BUS_36_36);

    // ----------------------------------------
    // Queue selection and offset
    // ----------------------------------------
    logic [QW-1:0] wq_q;
    logic [QW-1:0] rq_q;
    logic [CW-1:0] off_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            wq_q <= '0;
        end else if (wr_sel_en) begin
            wq_q <= wr_sel_addr;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rq_q <= '0;
        end else if (rd_sel_en) begin
            rq_q <= rd_sel_addr;
        end
    end

    // Reset is synchronous, so the select level is caught at a clock edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            off_q <= default_offset_select ? CW'(qsf_pkg::OFFSET_HI) : CW'(qsf_pkg::OFFSET_LO);
        end
    end

    // ----------------------------------------
    // Crossing delay lines
    // ----------------------------------------
    logic [2:0]    wlen;
    logic [2:0]    rlen;
    logic          wr_go;
    logic          rd_go;
    logic          wdel_v;
    logic [QW-1:0] wdel_q;
    logic          rdel_v;
    logic [QW-1:0] rdel_q;

    // A violated window costs one more cycle on either side
    assign wlen = 3'(pkt_eff ? qsf_pkg::SKEW_PKT_CYC : qsf_pkg::SKEW_WR_CYC) + {2'h0, skew_violate};
    assign rlen = 3'(qsf_pkg::SKEW_RD_CYC) + {2'h0, skew_violate};

    qsf_delay #(
        .MAXD (qsf_pkg::SKEW_MAX_CYC),
        .QW   (QW)
    ) u_wr_cross (
        .mclk  (mclk),
        .rst   (rst),
        .in_v  (wr_go),
        .in_q  (wq_q),
        .len   (wlen),
        .out_v (wdel_v),
        .out_q (wdel_q)
    );

    qsf_delay #(
        .MAXD (qsf_pkg::SKEW_MAX_CYC),
        .QW   (QW)
    ) u_rd_cross (
        .mclk  (mclk),
        .rst   (rst),
        .in_v  (rd_go),
        .in_q  (rq_q),
        .len   (rlen),
        .out_v (rdel_v),
        .out_q (rdel_q)
    );

    // ----------------------------------------
    // Per-queue occupancy
    // ----------------------------------------
    logic [CW-1:0] cnt_w_q [NQ];
    logic [CW-1:0] cnt_w_d [NQ];
    logic [CW-1:0] cnt_r_q [NQ];
    logic [CW-1:0] cnt_r_d [NQ];
    logic [NQ-1:0] same_q;
    logic [NQ-1:0] full_now;
    logic [NQ-1:0] full_d;
    logic [NQ-1:0] af_now;
    logic [NQ-1:0] af_s1_q;
    logic [NQ-1:0] bus_q;

    // Writes to a full queue and reads from an empty one are ignored
    assign wr_go = wr_en && !full_now[wq_q];
    assign rd_go = rd_en && (cnt_r_q[rq_q] >= outu);

    genvar gi;
    generate
        for (gi = 0; gi < NQ; gi++) begin : g_q
            logic          wr_hit;
            logic          rd_hit;
            logic          extra;
            logic          af_extra;
            logic [CW-1:0] cap;
            logic [CW-1:0] af_lvl;

            assign wr_hit = wr_go && (wq_q == QW'(gi));
            assign rd_hit = rd_go && (rq_q == QW'(gi));
            // The output register holds one more word only when nothing narrows the output
            assign extra  = same_q[gi] && !narrow_out;
            // A narrow input counts the extra word whatever the read port selects,
            // so an empty queue is never almost full before its first write
            assign af_extra = extra || narrow_in;
            // In quarter-word units the ratio folds in by itself
            assign cap    = to_units(CW'(DEPTH) + CW'(extra));
            assign af_lvl = to_units(CW'(DEPTH) + CW'(af_extra) - off_q);

            // Write-side view: own writes at once, reads after the window
            assign cnt_w_d[gi] = cnt_w_q[gi] + (wr_hit ? inu : '0)
                               - ((rdel_v && rdel_q == QW'(gi)) ? outu : '0);
            // Read-side view: own reads at once, writes after the window
            assign cnt_r_d[gi] = cnt_r_q[gi] + ((wdel_v && wdel_q == QW'(gi)) ? inu : '0)
                               - (rd_hit ? outu : '0);

            assign full_now[gi] = (cnt_w_q[gi] >= cap);
            assign full_d[gi]   = (cnt_w_d[gi] >= cap);
            assign af_now[gi]   = (cnt_w_q[gi] >= af_lvl);

            always_ff @(posedge mclk) begin
                if (rst) begin
                    cnt_w_q[gi] <= '0;
                end else begin
                    cnt_w_q[gi] <= cnt_w_d[gi];
                end
            end

            always_ff @(posedge mclk) begin
                if (rst) begin
                    cnt_r_q[gi] <= '0;
                end else begin
                    cnt_r_q[gi] <= cnt_r_d[gi];
                end
            end

            // Remember whether the first word went in with both ports on this queue
            always_ff @(posedge mclk) begin
                if (rst) begin
                    same_q[gi] <= 1'b0;
                end else if (wr_hit && cnt_w_q[gi] == '0) begin
                    same_q[gi] <= (rq_q == wq_q);
                end
            end

            // Two stages to assert, one to clear
            always_ff @(posedge mclk) begin
                if (rst) begin
                    af_s1_q[gi] <= 1'b0;
                end else begin
                    af_s1_q[gi] <= af_now[gi];
                end
            end

            always_ff @(posedge mclk) begin
                if (rst) begin
                    bus_q[gi] <= 1'b1;
                end else begin
                    bus_q[gi] <= !(af_now[gi] && af_s1_q[gi]);
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Flag outputs
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            output_valid_n <= 1'b1;
        end else begin
            // Falls as the delayed first word lands; rises at the emptying read
            output_valid_n <= !(cnt_r_d[rq_q] >= outu);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            queue_full_n <= 1'b1;
        end else begin
            queue_full_n <= !full_d[wq_q];
        end
    end

    // The active flag reads the registered selection, so a switch shows on the second edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            almost_full_n <= 1'b1;
        end else begin
            almost_full_n <= !(af_now[wq_q] && af_s1_q[wq_q]);
        end
    end

    // Bus bits carry no switch penalty here; the allowed extra cycle is never taken
    assign almost_full_bus = bus_q;

endmodule

// file: tb/qsf_host.sv
// Host read side: turns a bench read request into a read strobe.
// Assumes the flag logic's mclk and synchronous active-high rst.
`timescale 1ns/100ps
module qsf_host (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Bench request and read port
    input  wire logic rd_req,
    output logic      rd_en
);
    // Registered so that the strobe never changes near the sampling edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_en <= 1'b0;
        end else begin
            rd_en <= rd_req;
        end
    end
endmodule

// file: tb/qsf_flags_sva.sv
// Checker for flag timing of qsf_flags.
// Assumes one clock and a one-cycle crossing window.
`timescale 1ns/100ps
module qsf_flags_chk #(
    parameter int DEPTH = qsf_pkg::DEPTH_DEF,
    parameter int NQ    = qsf_pkg::NQ_DEF
) (
    // Clock and reset
    input wire logic                  mclk,
    input wire logic                  rst,
    // Configuration
    input wire logic [2:0]            bus_mode,
    input wire logic                  packet_mode,
    input wire logic                  default_offset_select,
    input wire logic                  skew_violate,
    // Ports
    input wire logic                  wr_sel_en,
    input wire logic [$clog2(NQ)-1:0] wr_sel_addr,
    input wire logic                  wr_en,
    input wire logic                  rd_sel_en,
    input wire logic [$clog2(NQ)-1:0] rd_sel_addr,
    input wire logic                  rd_en,
    // Flags
    input wire logic                  output_valid_n,
    input wire logic                  queue_full_n,
    input wire logic                  almost_full_n,
    input wire logic [NQ-1:0]         almost_full_bus
);
    logic [$clog2(NQ)-1:0] wq_q;
    logic [$clog2(NQ)-1:0] rq_q;
    logic [1:0]            sw_q;
    logic                  rq_ok;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    assign rq_ok = !rd_sel_en && !rd_en;
    // Recent write switches excuse the flags while they change queue
    always_ff @(posedge mclk) begin
        if (rst) begin
            wq_q <= '0;
            rq_q <= '0;
            sw_q <= '0;
        end else begin
            wq_q <= wr_sel_en ? wr_sel_addr : wq_q;
            rq_q <= rd_sel_en ? rd_sel_addr : rq_q;
            sw_q <= {sw_q[0], wr_sel_en};
        end
    end
    sequence s_first_wr;
        rq_ok ##1 rq_ok && wr_en && output_valid_n && !skew_violate && bus_mode == 3'h0 && wq_q == rq_q;
    endsequence
    sequence s_no_rd;
        rq_ok;
    endsequence
    property p_ov_set;
        s_first_wr ##1 s_no_rd |=> !output_valid_n;
    endproperty
    property p_ov_clr;
        $rose(output_valid_n) |-> $past(rd_en) || $past(rd_sel_en, 2);
    endproperty
    property p_ff_clr;
        $rose(queue_full_n) && sw_q == 2'h0 |-> $past(rd_en, 2) || $past(rd_en, 3);
    endproperty
    property p_ff_hold;
        !queue_full_n && !wr_sel_en && sw_q == 2'h0 && !$past(rd_en) && !$past(rd_en, 2) |=> !queue_full_n;
    endproperty
    property p_af_set;
        $fell(almost_full_n) && sw_q == 2'h0 |-> $past(wr_en, 3);
    endproperty
    property p_af_clr;
        $rose(almost_full_n) && sw_q == 2'h0 |-> $past(rd_en, 3) || $past(rd_en, 4);
    endproperty
    property p_bus;
        sw_q == 2'h0 |-> almost_full_n == almost_full_bus[wq_q];
    endproperty
    property p_rst;
        $fell(rst) |-> output_valid_n && queue_full_n && almost_full_n && &almost_full_bus;
    endproperty
    a_ov_set: assert property (p_ov_set) else $error("valid late");
    a_ov_clr: assert property (p_ov_clr) else $error("valid drop");
    a_ff_clr: assert property (p_ff_clr) else $error("full clear");
    a_ff_hold: assert property (p_ff_hold) else $error("full lost");
    a_af_set: assert property (p_af_set) else $error("af set");
    a_af_clr: assert property (p_af_clr) else $error("af clear");
    a_bus: assert property (p_bus) else $error("af bus");
    a_rst: assert property (p_rst) else $error("reset flags");
endmodule
bind qsf_flags qsf_flags_chk #(.DEPTH(DEPTH), .NQ(NQ)) i_qsf_flags_chk (.mclk, .rst, .bus_mode, .packet_mode,
    .default_offset_select, .skew_violate, .wr_sel_en, .wr_sel_addr, .wr_en, .rd_sel_en, .rd_sel_addr, .rd_en,
    .output_valid_n, .queue_full_n, .almost_full_n, .almost_full_bus);

// file: tb/tb.sv
// Bench for qsf_flags: valid timing, fills in every bus mode, drain, switch.
// Assumes qsf_host on the read port and the bound checker.
`timescale 1ns/100ps
module tb;
    localparam int D = 128;
    localparam int M = 8;
    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    logic [2:0] bus_mode = 3'h0;
    logic       packet_mode = 1'b0;
    logic       default_offset_select = 1'b0;
    logic       skew_violate = 1'b0;
    logic       wr_sel_en = 1'b0;
    logic [1:0] wr_sel_addr = 2'h0;
    logic       wr_en = 1'b0;
    logic       rd_sel_en = 1'b0;
    logic [1:0] rd_sel_addr = 2'h0;
    logic       rd_en;
    logic       rd_req = 1'b0;
    logic       output_valid_n;
    logic       queue_full_n;
    logic       almost_full_n;
    logic [3:0] almost_full_bus;
    logic [1:0] bq = 2'h0;
    logic [7:0] seed = 8'h55;
    logic [7:0] n;
    logic [7:0] note_q[$];
    int         miscompares = 0;
    int         check_count = 0;
    int         cycles = 0;

    always #20 mclk = ~mclk;

    qsf_flags #(.DEPTH(D), .NQ(4)) i_qsf_flags (.mclk, .rst, .bus_mode, .packet_mode, .default_offset_select,
        .skew_violate, .wr_sel_en, .wr_sel_addr, .wr_en, .rd_sel_en, .rd_sel_addr, .rd_en, .output_valid_n,
        .queue_full_n, .almost_full_n, .almost_full_bus);
    qsf_host i_qsf_host (.mclk, .rst, .rd_req, .rd_en);

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [3:0] seen, exp, msk);
        check_count++;
        if ((seen & msk) !== (exp & msk)) begin
            miscompares++;
            $display("mismatch t=%0t flags %b exp %b", $time, seen, exp);
        end
    endtask
    // Note bits: valid, full, almost full, bus bit of queue bq; mask above
    task automatic note(input logic [3:0] m, v);
        note_q.push_back({m, v});
    endtask
    always @(negedge mclk) begin
        while (note_q.size() > 0) begin
            n = note_q.pop_front();
            check({output_valid_n, queue_full_n, almost_full_n, almost_full_bus[bq]}, n[3:0], n[7:4]);
        end
    end
    // A hang would otherwise leave the queue unchecked forever
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 10000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
    endtask
    task automatic rst_dut(input logic [2:0] m, input logic d);
        @(posedge mclk);
        rst <= 1'b1;
        bus_mode <= m;
        default_offset_select <= d;
        cyc(4);
        rst <= 1'b0;
        cyc(1);
    endtask
    task automatic wr(input int k);
        repeat (k) begin
            @(posedge mclk);
            wr_en <= 1'b1;
        end
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input int k);
        repeat (k) begin
            @(posedge mclk);
            rd_req <= 1'b1;
        end
        @(posedge mclk);
        rd_req <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic sel(input logic [1:0] q);
        @(posedge mclk);
        wr_sel_en <= 1'b1;
        wr_sel_addr <= q;
        @(posedge mclk);
        wr_sel_en <= 1'b0;
    endtask
    task automatic valid_test(input logic p, s);
        rst_dut(3'h0, 1'b0);
        packet_mode <= p;
        skew_violate <= s;
        wr(1);
        note(4'h8, 4'h8);
        if (s) begin
            cyc(1);
            note(4'h8, 4'h8);
        end
        cyc(1);
        note(4'h8, 4'h0);
        // The crossing length is taken as the word lands, so the violation stays up until then
        skew_violate <= 1'b0;
        rd(1);
        note(4'h8, 4'h8);
        packet_mode <= 1'b0;
        $display("valid test p=%0d s=%0d done", p, s);
    endtask
    task automatic fill(input logic [2:0] m, input logic [1:0] q, input logic d, input int f, a);
        rst_dut(m, d);
        bq = q;
        if (q != 2'h0) sel(q);
        wr(a - 1);
        cyc(3);
        note(4'h3, 4'h3);
        wr(1);
        note(4'h3, 4'h3);
        cyc(1);
        note(4'h3, 4'h3);
        cyc(1);
        note(4'h3, 4'h0);
        wr(f - a - 1);
        note(4'h4, 4'h4);
        wr(1);
        note(4'hc, {q != 2'h0, 3'h0});
        wr(1);
        cyc(3);
        note(4'h6, 4'h0);
        $display("fill mode %0d queue %0d done", m, q);
    endtask

    initial begin
        for (int i = 0; i < 4; i++) valid_test(i[0], i[1]);
        fill(3'h0, 2'h0, 1'b0, D + 1, D + 1 - M);
        rd(1);
        note(4'h4, 4'h0);
        cyc(1);
        note(4'h6, 4'h4);
        rd(M);
        note(4'h3, 4'h0);
        cyc(1);
        note(4'h3, 4'h0);
        cyc(1);
        note(4'h3, 4'h3);
        $display("drain test done");
        fill(3'h1, 2'h0, 1'b0, D, D - M);
        // A late read crossing holds full one cycle longer
        skew_violate <= 1'b1;
        rd(1);
        note(4'h4, 4'h0);
        cyc(1);
        note(4'h4, 4'h0);
        cyc(1);
        skew_violate <= 1'b0;
        note(4'h4, 4'h4);
        $display("late clear test done");
        fill(3'h2, 2'h0, 1'b0, D, D - M);
        fill(3'h3, 2'h0, 1'b0, 2 * (D + 1), 2 * (D + 1 - M));
        fill(3'h4, 2'h0, 1'b0, 4 * (D + 1), 4 * (D + 1 - M));
        fill(3'h3, 2'h0, 1'b1, 2 * (D + 1), 2 * (D + 1 - 128));
        seed = lfsr(seed);
        fill(3'h0, 2'(seed % 3) + 2'h1, 1'b0, D, D - M);
        sel(2'h0);
        note(4'h2, 4'h0);
        cyc(1);
        note(4'h2, 4'h2);
        $display("switch test done");
        cyc(2);
        tally_and_finish();
    end
endmodule
